// file: src/cpag_addr_gen.sv
// Address generator for coefficient-pointer indirect operands addressing memory-mapped registers.
// Assumes one operand request per cycle from decode, qualified by i_req.
// Functional notes
// (RULE_01) Address keeps high part; low part plus optional circular base and offset.
// (RULE_02) Post-decrement 16-bit: use current pointer, then full pointer minus one.
// (RULE_03) Post-decrement 32-bit: use current pointer, then full pointer minus two.
// (RULE_04) Paired second address: even first plus one, odd first minus one.
// (RULE_05) Paired load: first word to first register, second word to next.
// (RULE_06) Constant offset: sign-extended 16-bit constant added; pointer unchanged.
// (RULE_07) Constant forms carry a 2-byte extension and never issue in parallel.
// (RULE_08) Pre-modify: constant added to full pointer first; updated value used and kept.
// (RULE_09) Full pointer is 23 bits: upper seven high, lower sixteen low.
// (RULE_10) Circular base added only when circular mode selected, else linear.
`timescale 1ns/10ps
`default_nettype none
module cpag_addr_gen (
    // Clock and reset.
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_resetn,
    // Operand request from decode.
    input  wire logic                       i_req,
    input  wire cpag_pkg::cpag_mode_t       i_mode,
    input  wire logic                       i_acc32,
    input  wire logic [15:0]                i_signed_offset_const,
    input  wire logic                       i_circ_en,
    input  wire logic [15:0]                i_coeff_circ_base,
    input  wire logic                       i_paired_issue,
    // Pointer load from software path.
    input  wire logic                       i_ptr_wr,
    input  wire logic [22:0]                i_ptr_wdata,
    // Data returned for a paired load.
    input  wire logic                       i_rd_valid,
    input  wire logic [15:0]                i_rd_word0,
    input  wire logic [15:0]                i_rd_word1,
    // Results.
    output logic                            o_addr_valid,
    output logic [22:0]                     o_addr_first,
    output logic [22:0]                     o_addr_second,
    output logic                            o_pair_valid,
    output logic [22:0]                     o_coeff_ptr_full,
    output logic [6:0]                      o_coeff_ptr_high,
    output logic [15:0]                     o_coeff_ptr_low,
    output logic [1:0]                      o_ext_bytes,
    output logic                            o_par_reject,
    output logic                            o_dst_wr,
    output logic [15:0]                     o_dst_first,
    output logic [15:0]                     o_dst_next
);
    import cpag_pkg::*;

    logic [FULL_W-1:0] ptr_r;
    logic [FULL_W-1:0] ptr_nxt;
    logic [FULL_W-1:0] base_ptr;
    logic [FULL_W-1:0] offset_ext;
    logic [LOW_W-1:0]  circ_add;
    logic [LOW_W-1:0]  low_sum;
    logic [FULL_W-1:0] eff_addr;
    logic [FULL_W-1:0] second_addr;
    logic              const_form;
    logic              go;
    logic              refuse;

    assign const_form  = (i_mode == CPAG_MODE_OFFSET) || (i_mode == CPAG_MODE_PREMOD);
    assign refuse      = i_req && const_form && i_paired_issue; // RULE_07
    assign go          = i_req && (i_mode != CPAG_MODE_NONE) && !refuse;
    assign offset_ext  = {{(FULL_W-LOW_W){i_signed_offset_const[LOW_W-1]}}, i_signed_offset_const}; // RULE_06
    // Pre-modify updates the pointer before the address is formed.
    assign base_ptr    = (i_mode == CPAG_MODE_PREMOD) ? ptr_r + offset_ext : ptr_r; // RULE_08
    assign circ_add    = i_circ_en ? i_coeff_circ_base : LOW_RESET; // RULE_10
    assign low_sum     = (i_mode == CPAG_MODE_OFFSET) ? base_ptr[LOW_W-1:0] + circ_add + i_signed_offset_const
                                                      : base_ptr[LOW_W-1:0] + circ_add;
    assign eff_addr    = {base_ptr[FULL_W-1:LOW_W], low_sum}; // RULE_01 RULE_09
    assign second_addr = {eff_addr[FULL_W-1:LOW_W],
                          eff_addr[0] ? eff_addr[LOW_W-1:0] - PAIR_STEP
                                      : eff_addr[LOW_W-1:0] + PAIR_STEP}; // RULE_04

    always_comb begin
        ptr_nxt = ptr_r;
        if (i_ptr_wr) begin
            ptr_nxt = i_ptr_wdata;
        end else if (go) begin
            case (i_mode)
                CPAG_MODE_POSTDEC: ptr_nxt = ptr_r - (i_acc32 ? STEP_32 : STEP_16); // RULE_02 RULE_03
                CPAG_MODE_OFFSET:  ptr_nxt = ptr_r; // RULE_06
                CPAG_MODE_PREMOD:  ptr_nxt = base_ptr; // RULE_08
                default:           ptr_nxt = ptr_r;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ptr_r <= PTR_RESET;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_addr_valid  <= 1'b0;
            o_addr_first  <= PTR_RESET;
            o_addr_second <= PTR_RESET;
            o_pair_valid  <= 1'b0;
            o_ext_bytes   <= 2'h0;
            o_par_reject  <= 1'b0;
        end else begin
            o_addr_valid  <= go;
            o_addr_first  <= go ? eff_addr : o_addr_first;
            o_addr_second <= go ? second_addr : o_addr_second;
            o_pair_valid  <= go && i_acc32;
            o_ext_bytes   <= (i_req && const_form) ? 2'(EXT_BYTES) : 2'h0; // RULE_07
            o_par_reject  <= refuse; // RULE_07
        end
    end

    // Pointer views are registered copies of the next pointer value.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_coeff_ptr_full <= PTR_RESET;
            o_coeff_ptr_high <= PTR_RESET[FULL_W-1:LOW_W];
            o_coeff_ptr_low  <= LOW_RESET;
        end else begin
            o_coeff_ptr_full <= ptr_nxt;
            o_coeff_ptr_high <= ptr_nxt[FULL_W-1:LOW_W]; // RULE_09
            o_coeff_ptr_low  <= ptr_nxt[LOW_W-1:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dst_wr    <= 1'b0;
            o_dst_first <= LOW_RESET;
            o_dst_next  <= LOW_RESET;
        end else begin
            o_dst_wr    <= i_rd_valid;
            o_dst_first <= i_rd_valid ? i_rd_word0 : o_dst_first; // RULE_05
            o_dst_next  <= i_rd_valid ? i_rd_word1 : o_dst_next; // RULE_05
        end
    end
endmodule
`default_nettype wire

// file: src/cpag_pkg.sv
// Package for the coefficient-pointer address generator.
// Assumes a 23-bit data address space split into a 7-bit high and a 16-bit low part.
package cpag_pkg;
    localparam int unsigned FULL_W = 23;
    localparam int unsigned LOW_W  = 16;
    localparam int unsigned HIGH_W = 7;
    localparam int unsigned EXT_BYTES = 2;

    localparam logic [FULL_W-1:0] STEP_16 = 23'h000001;
    localparam logic [FULL_W-1:0] STEP_32 = 23'h000002;
    localparam logic [LOW_W-1:0]  PAIR_STEP = 16'h0001;
    localparam logic [FULL_W-1:0] PTR_RESET = 23'h000000;
    localparam logic [LOW_W-1:0]  LOW_RESET = 16'h0000;

    typedef enum logic [1:0] {
        CPAG_MODE_POSTDEC = 2'b00,
        CPAG_MODE_OFFSET  = 2'b01,
        CPAG_MODE_PREMOD  = 2'b10,
        CPAG_MODE_NONE    = 2'b11
    } cpag_mode_t;
endpackage

// file: bench/cpag_assertions.sv
// Checker of the coefficient-pointer address generator.
// Bound to the design's ports below.
`timescale 1ns/10ps
`default_nettype none
module cpag_assertions (
    input wire logic i_clk_sys, i_resetn, i_req, i_acc32, i_circ_en, i_paired_issue, i_ptr_wr,
    input wire logic i_rd_valid, o_dst_wr, o_addr_valid, o_par_reject, o_pair_valid,
    input wire cpag_pkg::cpag_mode_t i_mode,
    input wire logic [15:0] i_rd_word0, o_dst_first, o_coeff_ptr_low, i_rd_word1, o_dst_next,
    input wire logic [22:0] o_addr_first, o_addr_second, o_coeff_ptr_full,
    input wire logic [6:0] o_coeff_ptr_high,
    input wire logic [1:0] o_ext_bytes);
    import cpag_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    wire cst = i_req && i_mode[0] != i_mode[1];
    wire tk = i_req && !i_ptr_wr && !i_circ_en && !(cst && i_paired_issue);
    chk_pair_addr: assert property (o_addr_valid |-> o_addr_second == (o_addr_first ^ 23'h1))
        else $error("pair address");
    chk_ptr_split: assert property (o_coeff_ptr_full == {o_coeff_ptr_high, o_coeff_ptr_low})
        else $error("pointer parts");
    chk_par_refuse: assert property (cst && i_paired_issue |=> o_par_reject && !o_addr_valid)
        else $error("no refusal");
    chk_ext_bytes: assert property (cst |=> o_ext_bytes == 2'h2) else $error("extension size");
    chk_dst_order: assert property (i_rd_valid |=> o_dst_wr && o_dst_first == $past(i_rd_word0))
        else $error("load order");
    chk_dst_next: assert property (i_rd_valid |=> o_dst_next == $past(i_rd_word1))
        else $error("second word");
    chk_post_dec: assert property (tk && i_mode == CPAG_MODE_POSTDEC |=> o_addr_first == $past(o_coeff_ptr_full)
        && o_coeff_ptr_full == o_addr_first - ($past(i_acc32) ? 23'h2 : 23'h1)) else $error("post-decrement");
    chk_off_keep: assert property (tk && i_mode == CPAG_MODE_OFFSET |=> $stable(o_coeff_ptr_full))
        else $error("offset moved pointer");
    chk_premod_use: assert property (tk && i_mode == CPAG_MODE_PREMOD |=> o_addr_first == o_coeff_ptr_full)
        else $error("pre-modify");
    cover property (cst && i_paired_issue);
    cover property (tk && i_mode == CPAG_MODE_PREMOD);
    cover property (o_pair_valid && o_addr_first[0]);
endmodule
bind cpag_addr_gen cpag_assertions u_chk (.*);
`default_nettype wire

// file: bench/tb_top.sv
// Bench of the coefficient-pointer address generator.
// Random requests are checked against a pointer model.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import cpag_pkg::*;
    logic i_clk_sys = 0, i_resetn = 0, i_req = 0, i_acc32 = 0, i_circ_en = 0, i_paired_issue = 0, i_ptr_wr = 0;
    logic i_rd_valid = 0, o_addr_valid, o_pair_valid, o_par_reject, o_dst_wr, rj;
    cpag_mode_t i_mode = CPAG_MODE_NONE;
    logic [15:0] i_signed_offset_const = 0, i_coeff_circ_base = 0, i_rd_word0 = 0, i_rd_word1 = 0;
    logic [15:0] o_coeff_ptr_low, o_dst_first, o_dst_next;
    logic [22:0] i_ptr_wdata = 0, o_addr_first, o_addr_second, o_coeff_ptr_full, ptr = 0, p, pm, sec;
    logic [6:0] o_coeff_ptr_high;
    logic [1:0] o_ext_bytes;
    logic [31:0] s = 32'h80ed;
    logic [47:0] q[$];
    logic [24:0] q2[$];
    logic [31:0] q3[$];
    int error_cnt = 0, n_compared = 0;
    cpag_addr_gen uut (.*);
    always #5 i_clk_sys = ~i_clk_sys;
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    task automatic summarize;
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(negedge i_clk_sys) begin
        if (o_addr_valid === 1'b1 || o_par_reject === 1'b1) begin
            chk({o_par_reject, o_pair_valid, o_addr_valid ? o_addr_first : 23'h0, o_coeff_ptr_full},
                q.size() ? q.pop_front() : 'x);
            chk(48'({o_ext_bytes, o_addr_valid ? o_addr_second : 23'h0}), 48'(q2.size() ? q2.pop_front() : 'x));
        end
        if (o_dst_wr === 1'b1)
            chk(48'({o_dst_first, o_dst_next}), 48'(q3.size() ? q3.pop_front() : 'x));
    end
    initial begin
        repeat (6) @(posedge i_clk_sys);
        #1 i_resetn = 1;
        repeat (800) begin
            @(posedge i_clk_sys);
            #1 s = xs(s);
            {i_req, i_acc32, i_circ_en, i_paired_issue, i_rd_valid, i_ptr_wr} = {s[4:0], s[10:7] == 4'h0};
            i_mode = cpag_mode_t'(s[6:5]);
            {i_signed_offset_const, i_coeff_circ_base} = s;
            {i_rd_word0, i_rd_word1} = s;
            i_ptr_wdata = s[31:9];
            // Pre-modify moves the whole pointer; base and offset stay within the low half.
            pm = ptr + (i_mode == CPAG_MODE_PREMOD ? {{7{s[31]}}, s[31:16]} : 23'h0);
            p = pm;
            p[15:0] = p[15:0] + (i_circ_en ? s[15:0] : 16'h0) + (i_mode == CPAG_MODE_OFFSET ? s[31:16] : 16'h0);
            sec = {p[22:16], p[0] ? p[15:0] - 16'h1 : p[15:0] + 16'h1};
            rj = i_mode[0] != i_mode[1] && i_paired_issue;
            if (i_rd_valid)
                q3.push_back({i_rd_word0, i_rd_word1});
            if (i_req && i_mode != CPAG_MODE_NONE)
                q2.push_back({i_mode[0] != i_mode[1] ? 2'h2 : 2'h0, rj ? 23'h0 : sec});
            if (i_req && i_mode != CPAG_MODE_NONE && !rj)
                ptr = i_mode == CPAG_MODE_POSTDEC ? ptr - (i_acc32 ? 23'h2 : 23'h1)
                    : (i_mode == CPAG_MODE_PREMOD ? pm : ptr);
            if (i_ptr_wr)
                ptr = i_ptr_wdata;
            if (i_req && i_mode != CPAG_MODE_NONE)
                q.push_back({rj, !rj && i_acc32, rj ? 23'h0 : p, ptr});
        end
        @(posedge i_clk_sys);
        #1 i_req = 0;
        i_ptr_wr = 0;
        i_rd_valid = 0;
        repeat (3) @(posedge i_clk_sys);
        chk(48'(q.size() + q2.size() + q3.size()), 48'h0);
        summarize();
    end
endmodule
`default_nettype wire
